//--- pkg/lis_defs.svh
// Constants of the laser interlock and status sequencer: offsets, fields, resets, timing.
// Assumes a 100 MHz system clock and a byte-addressed plain register port.
`ifndef LIS_DEFS_SVH
`define LIS_DEFS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define LIS_CLK_HZ          32'h05F5_E100
`define LIS_HZ_PER_MHZ      32'h000F_4240
`define LIS_START_DELAY_S   32'h0000_0005
`define LIS_CW_PERIOD_US    32'h0000_0032
`define LIS_START_DLY_CYC   (`LIS_START_DELAY_S * `LIS_CLK_HZ)
`define LIS_CW_CYC          ((`LIS_CLK_HZ / `LIS_HZ_PER_MHZ) * `LIS_CW_PERIOD_US)

// ----------------------------------------------------------------------------
// Fault thresholds
// ----------------------------------------------------------------------------
`define LIS_TEMP_LIMIT_C    8'h3C

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LIS_OFS_CTRL        8'h00
`define LIS_OFS_STATUS      8'h04
`define LIS_OFS_CAUSE       8'h08
`define LIS_OFS_DBNC        8'h0C
`define LIS_OFS_PWM_PER     8'h10
`define LIS_OFS_PWM_HIGH    8'h14

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define LIS_CTRL_INHIBIT    0
`define LIS_ST_LOOP         4
`define LIS_ST_FAULT        5
`define LIS_ST_CW           6
`define LIS_ST_READY        7
`define LIS_ST_SUPPLY       8
`define LIS_ST_OVER_FREQ    9
`define LIS_CAUSE_CIRCUIT   0
`define LIS_CAUSE_OVER_V    1
`define LIS_CAUSE_UNDER_V   2
`define LIS_CAUSE_TEMP      3
`define LIS_CTRL_RST        1'h0
`define LIS_DBNC_RST        16'h2710

`endif

//--- pkg/lis_pkg.sv
// Types shared by the sequencer top and its timer and debounce leaves.
// Assumes the constants header is found on the include path.
`include "lis_defs.svh"

package lis_pkg;

  typedef enum logic [2:0] {
    LIS_STARTUP,
    LIS_OPEN,
    LIS_DELAY,
    LIS_ARMED,
    LIS_FAULT
  } lis_state_e;

  typedef struct packed {
    lis_state_e  st;
    logic        started;
    logic        tmr_start;
    logic        inhibit;
    logic [15:0] dbnc_lim;
    logic [3:0]  cause;
    logic        fault_n;
    logic        rf_pwr;
    logic        supply;
    logic        ready;
    logic        emis;
    logic        drive;
    logic        cw;
    logic        over_freq;
    logic        pwm_prev;
    logic [31:0] hi_cnt;
    logic [31:0] per_cnt;
    logic [31:0] high_cnt;
    logic [31:0] pwm_per;
    logic [31:0] pwm_high;
    logic [31:0] rdata;
  } lis_top_s;

  typedef struct packed {
    logic [31:0] cnt;
    logic        run;
    logic        done;
  } lis_tmr_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic        stable;
  } lis_dbn_s;

  // Saturating increment, so long idle levels never wrap a measurement.
  function automatic logic [31:0] lis_sat_inc(input logic [31:0] x);
    lis_sat_inc = (x == 32'hFFFF_FFFF) ? x : x + 32'h0000_0001;
  endfunction : lis_sat_inc

endpackage : lis_pkg

//--- rtl/lis_debounce.sv
// Debouncer for the interlock loop: the output follows only a level that stood long enough.
// Assumes the raw input is synchronous to the clock; limit may change at any time.
`timescale 1ns/1ns

module lis_debounce
  import lis_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        raw_i,
  input  wire logic [15:0] limit_i,
  output logic             stable_o
);

  lis_dbn_s q;
  lis_dbn_s d;

  always_comb
  begin
    d = q;
    if (raw_i == q.stable)
    begin
      d.cnt = 16'h0000;
    end
    else if (q.cnt >= limit_i)
    begin
      d.stable = raw_i;
      d.cnt    = 16'h0000;
    end
    else
    begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  // Starts as open, so a closed loop is only trusted after a full interval.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign stable_o = q.stable;

endmodule : lis_debounce

//--- rtl/lis_timer.sv
// One-shot delay timer: a start pulse loads a count, done rises when it runs out.
// Assumes a start pulse of one cycle; done holds until the next start.
`timescale 1ns/1ns

module lis_timer
  import lis_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [31:0] load_i,
  output logic             done_o
);

  lis_tmr_s q;
  lis_tmr_s d;

  always_comb
  begin
    d = q;
    if (start_i)
    begin
      d.cnt  = (load_i == 32'h0000_0000) ? 32'h0000_0000 : load_i - 32'h0000_0001;
      d.run  = 1'b1;
      d.done = 1'b0;
    end
    else if (q.run)
    begin
      if (q.cnt == 32'h0000_0000)
      begin
        d.run  = 1'b0;
        d.done = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign done_o = q.done;

endmodule : lis_timer

//--- rtl/lis_top.sv
// Interlock, start-up delay, fault latch and indicator logic of the laser user port.
// Assumes all pins are synchronous to CLK_SYS_I and that reset is the power-up reset.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns

module lis_top
  import lis_pkg::*;
#(
  parameter int unsigned START_DLY_CYC = `LIS_START_DLY_CYC,
  parameter int unsigned CW_CYC        = `LIS_CW_CYC
)
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic [31:0]      REG_RDATA_O,
  input  wire logic        KEY_ON_I,
  input  wire logic        KEY_BYPASS_I,
  input  wire logic        INTERLOCK_LOOP_I,
  input  wire logic        FAULT_CIRCUIT_I,
  input  wire logic        OVER_VOLT_I,
  input  wire logic        UNDER_VOLT_I,
  input  wire logic [7:0]  TEMP_C_I,
  input  wire logic        PWM_CMD_I,
  output logic             INTERLOCK_SUPPLY_O,
  output logic             FAULT_N_O,
  output logic             RF_POWER_O,
  output logic             RF_DRIVE_O,
  output logic             EMISSION_INDICATOR_OUT_O,
  output logic             READY_INDICATOR_OUT_O,
  output logic             CONTINUOUS_EMISSION_MODE_O
);

  // --------------------------------------------------------------------------
  // State and leaf connections
  // --------------------------------------------------------------------------
  lis_top_s    q;
  lis_top_s    d;
  logic        dbn_closed;
  logic        tmr_done;
  logic        loop_closed;
  logic        temp_hot;
  logic [3:0]  raw_cause;
  logic        fault_now;
  logic        pwm_rise;
  logic        pwm_fall;
  logic [31:0] status_word;

  lis_debounce u_debounce (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (RST_N_I),
    .raw_i    (INTERLOCK_LOOP_I),
    .limit_i  (q.dbnc_lim),
    .stable_o (dbn_closed)
  );

  lis_timer u_timer (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RST_N_I),
    .start_i (q.tmr_start),
    .load_i  (32'(START_DLY_CYC)),
    .done_o  (tmr_done)
  );

  // --------------------------------------------------------------------------
  // Loop and fault detection
  // --------------------------------------------------------------------------
  // act on the debounced loop only
  // Loop current flows only from the supply pin, so an unpowered supply reads as open.
  assign loop_closed = dbn_closed & q.supply;

  assign temp_hot = (TEMP_C_I > `LIS_TEMP_LIMIT_C);

  always_comb
  begin
    raw_cause                     = 4'h0;
    raw_cause[`LIS_CAUSE_CIRCUIT] = FAULT_CIRCUIT_I;
    raw_cause[`LIS_CAUSE_OVER_V]  = OVER_VOLT_I;
    raw_cause[`LIS_CAUSE_UNDER_V] = UNDER_VOLT_I;
    raw_cause[`LIS_CAUSE_TEMP]    = temp_hot;
  end

  assign fault_now = |raw_cause;
  assign pwm_rise  = PWM_CMD_I & ~q.pwm_prev;
  assign pwm_fall  = ~PWM_CMD_I & q.pwm_prev;

  always_comb
  begin
    status_word                     = 32'h0000_0000;
    status_word[2:0]                = q.st;
    status_word[`LIS_ST_LOOP]       = loop_closed;
    status_word[`LIS_ST_FAULT]      = ~q.fault_n;
    status_word[`LIS_ST_CW]         = q.cw;
    status_word[`LIS_ST_READY]      = q.ready;
    status_word[`LIS_ST_SUPPLY]     = q.supply;
    status_word[`LIS_ST_OVER_FREQ]  = q.over_freq;
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    d           = q;
    d.tmr_start = 1'b0;
    d.rdata     = 32'h0000_0000;
    d.pwm_prev  = PWM_CMD_I;

    // Register writes.
    if (REG_WR_I)
    begin
      unique case (REG_ADDR_I)
        `LIS_OFS_CTRL:
        begin
          d.inhibit = REG_WDATA_I[`LIS_CTRL_INHIBIT];
        end
        `LIS_OFS_DBNC:
        begin
          d.dbnc_lim = REG_WDATA_I[15:0];
        end
        default:
        begin
        end
      endcase
    end

    // Read data stands for one cycle only; unmapped offsets read zero.
    if (REG_RD_I)
    begin
      unique case (REG_ADDR_I)
        `LIS_OFS_CTRL:     d.rdata = {31'h0000_0000, q.inhibit};
        `LIS_OFS_STATUS:   d.rdata = status_word;
        `LIS_OFS_CAUSE:    d.rdata = {28'h000_0000, q.cause};
        `LIS_OFS_DBNC:     d.rdata = {16'h0000, q.dbnc_lim};
        `LIS_OFS_PWM_PER:  d.rdata = q.pwm_per;
        `LIS_OFS_PWM_HIGH: d.rdata = q.pwm_high;
        default:           d.rdata = 32'h0000_0000;
      endcase
    end

    // supply only with key on or bypassed
    d.supply = KEY_ON_I | KEY_BYPASS_I;

    // open loop clears the latched causes
    // A cause still present in the clearing cycle is kept, so the set wins.
    if (!loop_closed)
    begin
      d.cause = raw_cause;
    end
    else
    begin
      d.cause = q.cause | raw_cause;
    end

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    unique case (q.st)
      LIS_STARTUP:
      begin
        if (!q.started)
        begin
          d.started   = 1'b1;
          d.tmr_start = 1'b1;
        end
        else if (tmr_done && !q.tmr_start)
        begin
          if (!loop_closed)
          begin
            d.st = LIS_OPEN;
          end
          else if (fault_now || (q.cause != 4'h0))
          begin
            d.st = LIS_FAULT;
          end
          else
          begin
            d.st = LIS_ARMED;
          end
        end
      end
      LIS_OPEN:
      begin
        if (loop_closed)
        begin
          if (fault_now)
          begin
            d.st = LIS_FAULT;
          end
          else
          begin
            d.st        = LIS_DELAY;
            d.tmr_start = 1'b1;
          end
        end
      end
      LIS_DELAY:
      begin
        // opening the loop halts at once
        if (!loop_closed)
        begin
          d.st = LIS_OPEN;
        end
        else if (fault_now)
        begin
          d.st = LIS_FAULT;
        end
        // lasing enabled once the delay expires
        else if (tmr_done && !q.tmr_start)
        begin
          d.st = LIS_ARMED;
        end
      end
      LIS_ARMED:
      begin
        if (!loop_closed)
        begin
          d.st = LIS_OPEN;
        end
        else if (fault_now)
        begin
          d.st = LIS_FAULT;
        end
      end
      LIS_FAULT:
      begin
        // loop toggle resets the fault
        // Power cycling resets it too, since that is the power-up reset.
        if (!loop_closed)
        begin
          d.st = LIS_OPEN;
        end
      end
    endcase

    // ------------------------------------------------------------------------
    // Command measurement
    // ------------------------------------------------------------------------
    // constant-high command detected as continuous emission
    if (PWM_CMD_I)
    begin
      d.hi_cnt = lis_sat_inc(q.hi_cnt);
    end
    else
    begin
      d.hi_cnt = 32'h0000_0000;
    end
    d.cw = (d.hi_cnt >= 32'(CW_CYC));

    // Period is captured on each rising edge of the command, high time on each falling edge.
    d.per_cnt = lis_sat_inc(q.per_cnt);
    if (PWM_CMD_I)
    begin
      d.high_cnt = lis_sat_inc(q.high_cnt);
    end
    if (pwm_fall)
    begin
      d.pwm_high = q.high_cnt;
    end
    if (pwm_rise)
    begin
      d.pwm_per  = q.per_cnt;
      d.per_cnt  = 32'h0000_0001;
      d.high_cnt = 32'h0000_0001;
    end

    // flag a command faster than allowed
    // Cleared by writing one to its status bit; a new edge in that cycle wins.
    if (REG_WR_I && (REG_ADDR_I == `LIS_OFS_STATUS) && REG_WDATA_I[`LIS_ST_OVER_FREQ])
    begin
      d.over_freq = 1'b0;
    end
    if (pwm_rise && (q.per_cnt < 32'(CW_CYC)) && (q.pwm_per != 32'h0000_0000))
    begin
      d.over_freq = 1'b1;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // fault output low while detected or latched
    d.fault_n = ~(fault_now || (d.st == LIS_FAULT));

    // RF power only in the powered states
    d.rf_pwr = (d.st == LIS_DELAY) || (d.st == LIS_ARMED);

    // drive only when armed with a closed loop
    // no pulse or tickle without RF power
    // constant command passes as a fixed level
    d.drive = PWM_CMD_I && (d.st == LIS_ARMED) && d.rf_pwr && !q.inhibit;

    // indicator follows the gated command waveform
    d.emis = d.drive;

    // ready while the laser is enabled
    // ready drops when lasing is disabled
    d.ready = d.rf_pwr && !q.inhibit;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      q          <= '0;
      q.st       <= LIS_STARTUP;
      q.inhibit  <= `LIS_CTRL_RST;
      q.dbnc_lim <= `LIS_DBNC_RST;
      q.fault_n  <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign REG_RDATA_O                = q.rdata;
  assign INTERLOCK_SUPPLY_O         = q.supply;
  assign FAULT_N_O                  = q.fault_n;
  assign RF_POWER_O                 = q.rf_pwr;
  assign RF_DRIVE_O                 = q.drive;
  assign EMISSION_INDICATOR_OUT_O   = q.emis;
  assign READY_INDICATOR_OUT_O      = q.ready;
  assign CONTINUOUS_EMISSION_MODE_O = q.cw;

endmodule : lis_top

//--- tb/lis_far_side.sv
// Far-side controller model: gated command source that halts while a fault is shown.
// Assumes the bench sets period, high time and gate mode; shares the device clock.
`timescale 1ns/1ns

module lis_far_side (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        gate_off_mode_i,
  input  wire logic        gate_conn_i,
  input  wire logic        gate_hi_i,
  input  wire logic        cw_i,
  input  wire logic        fault_n_i,
  input  wire logic [15:0] per_i,
  input  wire logic [15:0] high_i,
  output logic             pwm_o
);
  logic [15:0] cnt_q;
  logic        gate_ok;

  assign gate_ok = gate_off_mode_i ? (gate_conn_i && gate_hi_i) : (!gate_conn_i || gate_hi_i);

  // period kept slow
  // The bench scales the period to cycles, above the continuous-mode threshold except in its too-fast check.
  always @(posedge clk_i)
  begin
    if (!rst_n_i || cnt_q + 16'h0001 >= per_i)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_q + 16'h0001;
  end

  always @(posedge clk_i)
  begin
    pwm_o <= rst_n_i && gate_ok && fault_n_i && (cw_i || cnt_q < high_i);
  end
endmodule : lis_far_side

//--- tb/lis_top_assertions.sv
// Checker for the interlock sequencer top: timing relations between its pins.
// Assumes it is bound to lis_top and sees only that module's ports.
`timescale 1ns/1ns

module lis_top_assertions #(
  parameter int unsigned START_DLY_CYC = 50,
  parameter int unsigned CW_CYC        = 20
)
(
  input wire logic       CLK_SYS_I,
  input wire logic       RST_N_I,
  input wire logic       KEY_ON_I,
  input wire logic       KEY_BYPASS_I,
  input wire logic       INTERLOCK_LOOP_I,
  input wire logic       FAULT_CIRCUIT_I,
  input wire logic       OVER_VOLT_I,
  input wire logic       UNDER_VOLT_I,
  input wire logic [7:0] TEMP_C_I,
  input wire logic       PWM_CMD_I,
  input wire logic       INTERLOCK_SUPPLY_O,
  input wire logic       FAULT_N_O,
  input wire logic       RF_POWER_O,
  input wire logic       RF_DRIVE_O,
  input wire logic       EMISSION_INDICATOR_OUT_O,
  input wire logic       READY_INDICATOR_OUT_O,
  input wire logic       CONTINUOUS_EMISSION_MODE_O
);
  logic        up_q;
  logic [31:0] on_cnt_q;
  logic [31:0] hi_run_q;

  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);

  // ----
  // Helpers
  // ----
  // The on counter restarts only well after boot, so the boot path to armed is not
  // mistaken for a fresh loop closure.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      up_q     <= 1'b0;
      on_cnt_q <= 32'h0000_0000;
      hi_run_q <= 32'h0000_0000;
    end
    else
    begin
      up_q     <= 1'b1;
      on_cnt_q <= (!RF_POWER_O && on_cnt_q >= START_DLY_CYC + 16) ? 32'h0000_0000 : on_cnt_q + 1;
      hi_run_q <= PWM_CMD_I ? hi_run_q + 1 : 32'h0000_0000;
    end
  end

  sequence s_fault_edge;
    $fell(FAULT_N_O);
  endsequence

  sequence s_rf_up;
    $rose(RF_POWER_O);
  endsequence

  // ----
  // Assertions
  // ----
  a_supply_key: assert property (up_q |-> INTERLOCK_SUPPLY_O == $past(KEY_ON_I || KEY_BYPASS_I))
    else $error("supply output does not follow the key");
  a_fault_out: assert property ((FAULT_CIRCUIT_I || OVER_VOLT_I || UNDER_VOLT_I ||
    TEMP_C_I > 8'h3C) |=> !FAULT_N_O) else $error("fault output not low on a fault");
  a_fault_halts: assert property (s_fault_edge |=> (!RF_DRIVE_O && !RF_POWER_O) [*3])
    else $error("drive or power left on after a fault");
  a_drive_power: assert property (RF_DRIVE_O |-> RF_POWER_O && $past(PWM_CMD_I))
    else $error("drive without power or command");
  a_emis_mirror: assert property (EMISSION_INDICATOR_OUT_O == RF_DRIVE_O)
    else $error("emission indicator differs from drive");
  a_ready_power: assert property (READY_INDICATOR_OUT_O |-> RF_POWER_O)
    else $error("ready indicator without power");
  a_loop_needed: assert property (s_rf_up |-> $past(INTERLOCK_LOOP_I, 2))
    else $error("power rose with the loop open");
  a_start_delay: assert property (RF_DRIVE_O |-> on_cnt_q >= START_DLY_CYC)
    else $error("drive before the start delay ran out");
  a_cw_run: assert property ($rose(CONTINUOUS_EMISSION_MODE_O) |-> hi_run_q + 2 >= CW_CYC)
    else $error("continuous mode flagged too early");
endmodule : lis_top_assertions

bind lis_top lis_top_assertions #(.START_DLY_CYC(START_DLY_CYC), .CW_CYC(CW_CYC)) u_lis_chk (
  .CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .KEY_ON_I(KEY_ON_I), .KEY_BYPASS_I(KEY_BYPASS_I),
  .INTERLOCK_LOOP_I(INTERLOCK_LOOP_I), .FAULT_CIRCUIT_I(FAULT_CIRCUIT_I),
  .OVER_VOLT_I(OVER_VOLT_I), .UNDER_VOLT_I(UNDER_VOLT_I), .TEMP_C_I(TEMP_C_I),
  .PWM_CMD_I(PWM_CMD_I), .INTERLOCK_SUPPLY_O(INTERLOCK_SUPPLY_O), .FAULT_N_O(FAULT_N_O),
  .RF_POWER_O(RF_POWER_O), .RF_DRIVE_O(RF_DRIVE_O),
  .EMISSION_INDICATOR_OUT_O(EMISSION_INDICATOR_OUT_O),
  .READY_INDICATOR_OUT_O(READY_INDICATOR_OUT_O),
  .CONTINUOUS_EMISSION_MODE_O(CONTINUOUS_EMISSION_MODE_O));

//--- tb/tb.sv
// Self-checking bench of the interlock sequencer top with a far-side command source.
// Assumes the design, its package, the checker and the far-side model are compiled first.
`timescale 1ns/1ns
`include "lis_defs.svh"

module tb;
  import lis_pkg::*;

  localparam int unsigned START_CYC = 50;
  localparam int unsigned CWC       = 20;
  localparam int          DBN       = 6;
  localparam int          RFP       = 0;
  localparam int          DRV       = 1;
  localparam int          CWM       = 2;
  localparam int          CMD       = 3;

  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] rdata;
  logic        key_on;
  logic        key_byp;
  logic        loop;
  logic [2:0]  src;
  logic [7:0]  temp;
  logic        pwm;
  logic        supply;
  logic        fault_n;
  logic        rf_pwr;
  logic        rf_drv;
  logic        emis;
  logic        ready;
  logic        cw_mode;
  logic        pcw;
  logic [15:0] per;
  logic [15:0] hi;
  int          miscompares;
  int          n_compared;
  int          cyc;

  lis_top #(.START_DLY_CYC(START_CYC), .CW_CYC(CWC)) u_dut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(rdata), .KEY_ON_I(key_on),
    .KEY_BYPASS_I(key_byp), .INTERLOCK_LOOP_I(loop), .FAULT_CIRCUIT_I(src[0]),
    .OVER_VOLT_I(src[1]), .UNDER_VOLT_I(src[2]), .TEMP_C_I(temp), .PWM_CMD_I(pwm),
    .INTERLOCK_SUPPLY_O(supply), .FAULT_N_O(fault_n), .RF_POWER_O(rf_pwr),
    .RF_DRIVE_O(rf_drv), .EMISSION_INDICATOR_OUT_O(emis), .READY_INDICATOR_OUT_O(ready),
    .CONTINUOUS_EMISSION_MODE_O(cw_mode));

  // The integrated setup reads the gate as normally off, driven high.
  lis_far_side u_far (
    .clk_i(clk), .rst_n_i(rst_n), .gate_off_mode_i(1'b1), .gate_conn_i(1'b1),
    .gate_hi_i(1'b1), .cw_i(pcw), .fault_n_i(fault_n), .per_i(per), .high_i(hi), .pwm_o(pwm));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) cyc <= rst_n ? cyc + 1 : 0;

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk_w(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_w

  task automatic chk_b(input string what, input logic exp, input logic got);
    chk_w(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask : chk_b

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  function automatic logic pin(input int sel);
    case (sel)
      RFP:     pin = rf_pwr;
      DRV:     pin = rf_drv;
      CWM:     pin = cw_mode;
      default: pin = pwm;
    endcase
  endfunction : pin

  // A wait that runs out ends the run at once with a mismatch counted.
  task automatic wait_lvl(input int sel, input logic v, input int maxc, output int n);
    n = 0;
    while (pin(sel) !== v)
    begin
      if (n == maxc)
      begin
        miscompares++;
        $display("ERROR wait on pin %0d expected %b seen %b", sel, v, pin(sel));
        give_verdict();
      end
      tick(1);
      n++;
    end
  endtask : wait_lvl

  task automatic set_loop(input logic v);
    @(posedge clk);
    loop <= v;
  endtask : set_loop

  task automatic t_boot();
    logic [31:0] d;
    int          n;
    bus_rd(`LIS_OFS_DBNC, d);
    chk_w("dbnc_reset", {16'h0000, `LIS_DBNC_RST}, d);
    bus_wr(`LIS_OFS_DBNC, DBN);
    bus_rd(`LIS_OFS_DBNC, d);
    chk_w("dbnc_rw", DBN, d);
    bus_rd(`LIS_OFS_CTRL, d);
    chk_w("ctrl_reset", 32'h0000_0000, d);
    bus_rd(8'h20, d);
    chk_w("unmapped", 32'h0000_0000, d);
    bus_rd(`LIS_OFS_STATUS, d);
    chk_w("boot_state", 32'h0000_0000, {29'h0000_0000, d[2:0]});
    chk_b("boot_no_power", 1'b0, rf_pwr);
    wait_lvl(RFP, 1'b1, 200, n);
    chk_b("boot_delay_min", 1'b1, cyc >= START_CYC);
    chk_b("boot_delay_max", 1'b1, cyc <= START_CYC + 8);
  endtask : t_boot

  task automatic t_mirror();
    logic        prev;
    logic [31:0] d;
    tick(45);
    prev = pwm;
    repeat (80)
    begin
      tick(1);
      chk_b("emis_eq_drive", rf_drv, emis);
      chk_b("drive_follows_cmd", prev, rf_drv);
      prev = pwm;
    end
    chk_b("modulated_not_cw", 1'b0, cw_mode);
    bus_rd(`LIS_OFS_PWM_PER, d);
    chk_w("pwm_period", {16'h0000, per}, d);
    bus_rd(`LIS_OFS_PWM_HIGH, d);
    chk_w("pwm_high", {16'h0000, hi}, d);
    // A period of ten cycles is below the continuous-mode threshold, so it is too fast.
    @(posedge clk);
    per <= 16'h000A;
    hi  <= 16'h0005;
    tick(30);
    bus_rd(`LIS_OFS_STATUS, d);
    chk_b("over_freq_set", 1'b1, d[`LIS_ST_OVER_FREQ]);
    @(posedge clk);
    per <= 16'h0028;
    hi  <= 16'h000A;
    tick(50);
    bus_wr(`LIS_OFS_STATUS, 32'h0000_0200);
    bus_rd(`LIS_OFS_STATUS, d);
    chk_b("over_freq_clear", 1'b0, d[`LIS_ST_OVER_FREQ]);
  endtask : t_mirror

  task automatic t_cw();
    logic [31:0] d;
    int          n;
    @(posedge clk);
    hi <= 16'h0000;
    tick(3);
    @(posedge clk);
    pcw <= 1'b1;
    wait_lvl(CMD, 1'b1, 10, n);
    wait_lvl(CWM, 1'b1, CWC + 6, n);
    chk_b("cw_after_run", 1'b1, n >= CWC - 2);
    bus_rd(`LIS_OFS_STATUS, d);
    chk_b("status_cw", 1'b1, d[`LIS_ST_CW]);
  endtask : t_cw

  task automatic reclose();
    int n;
    set_loop(1'b0);
    tick(DBN + 6);
    chk_b("open_clears_fault", 1'b1, fault_n);
    chk_b("open_no_power", 1'b0, rf_pwr);
    chk_b("open_no_drive", 1'b0, rf_drv);
    chk_b("open_not_ready", 1'b0, ready);
    set_loop(1'b1);
    wait_lvl(RFP, 1'b1, DBN + 8, n);
    tick(1);
    chk_b("ready_on_power", 1'b1, ready);
    wait_lvl(DRV, 1'b1, START_CYC + 12, n);
    chk_b("start_delay", 1'b1, n >= START_CYC - 2);
  endtask : reclose

  task automatic t_fault(input int idx);
    logic [31:0] d;
    @(posedge clk);
    if (idx < 3)
      src[idx] <= 1'b1;
    else
      temp <= 8'h3D;
    tick(3);
    chk_b("fault_low", 1'b0, fault_n);
    chk_b("fault_no_power", 1'b0, rf_pwr);
    chk_b("fault_not_ready", 1'b0, ready);
    bus_rd(`LIS_OFS_CAUSE, d);
    chk_w("cause", 32'h0000_0001 << idx, d);
    @(posedge clk);
    src  <= 3'h0;
    temp <= 8'h19;
    tick(3);
    chk_b("fault_latched", 1'b0, fault_n);
    set_loop(1'b0);
    tick(2);
    set_loop(1'b1);
    tick(DBN + 4);
    chk_b("short_open_ignored", 1'b0, fault_n);
    reclose();
  endtask : t_fault

  task automatic t_inhibit();
    logic [31:0] d;
    @(posedge clk);
    temp <= 8'h3C;
    tick(4);
    chk_b("temp_at_limit_ok", 1'b1, fault_n);
    bus_wr(`LIS_OFS_CTRL, 32'h0000_0001);
    tick(3);
    chk_b("inhibit_not_ready", 1'b0, ready);
    chk_b("inhibit_no_drive", 1'b0, rf_drv);
    bus_rd(`LIS_OFS_CTRL, d);
    chk_w("ctrl_rw", 32'h0000_0001, d);
    bus_wr(`LIS_OFS_CTRL, 32'h0000_0000);
    tick(3);
    chk_b("ready_again", 1'b1, ready);
  endtask : t_inhibit

  task automatic t_supply();
    @(posedge clk);
    key_byp <= 1'b0;
    tick(3);
    chk_b("supply_key_off", 1'b0, supply);
    @(posedge clk);
    key_on <= 1'b1;
    tick(3);
    chk_b("supply_key_on", 1'b1, supply);
  endtask : t_supply

  initial
  begin
    rst_n       = 1'b0;
    addr        = 8'h00;
    wdata       = 32'h0000_0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    key_on      = 1'b0;
    key_byp     = 1'b1;
    loop        = 1'b1;
    src         = 3'h0;
    temp        = 8'h19;
    pcw         = 1'b0;
    per         = 16'h0028;
    hi          = 16'h000A;
    miscompares = 0;
    n_compared  = 0;
    cyc         = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_boot();
    t_mirror();
    t_cw();
    for (int i = 0; i < 4; i++)
      t_fault(i);
    t_inhibit();
    t_supply();
    give_verdict();
  end
endmodule : tb
